// file: payload_aligner_pkg.sv
// package of constants and carriers for the receive payload aligner register bank.
// assumes a 16-bit processor port and a stream of one byte per clock.
package payload_aligner_pkg;

	localparam int NUM_PATHS = 12;

	// ------------------------------------------------------------
	// direct register offsets
	// ------------------------------------------------------------
	localparam logic [15:0] OFS_IND_ADDR = 16'h0200;
	localparam logic [15:0] OFS_IND_DATA = 16'h0201;
	localparam logic [15:0] OFS_PAYLOAD_CFG = 16'h0202;
	localparam logic [15:0] OFS_POS_JUST_FLAGS = 16'h0203;
	localparam logic [15:0] OFS_NEG_JUST_FLAGS = 16'h0204;
	localparam logic [15:0] OFS_OVERFLOW_FLAGS = 16'h0205;
	localparam logic [15:0] OFS_UNDERFLOW_FLAGS = 16'h0206;
	localparam logic [15:0] OFS_JUST_IRQ_EN = 16'h0207;
	localparam logic [15:0] OFS_FIFO_IRQ_EN = 16'h0208;
	localparam logic [15:0] OFS_STUFF_REGEN = 16'h020A;
	localparam logic [15:0] OFS_SNAPSHOT = 16'h020B;

	// ------------------------------------------------------------
	// indirect register indices
	// ------------------------------------------------------------
	localparam logic [1:0] IND_POS_COUNT = 2'h0;
	localparam logic [1:0] IND_NEG_COUNT = 2'h1;
	localparam logic [1:0] IND_DIAG = 2'h2;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int IA_BUSY_BIT = 15;
	localparam int IA_RNW_BIT = 14;
	localparam int IA_SEL_LSB = 8;
	localparam int BYPASS_BIT = 15;
	localparam int PC_STS12C_BIT = 14;
	localparam int PC_TUG3_LSB = 4;
	localparam int DG_REINIT_BIT = 15;
	localparam int DG_SS_LSB = 13;
	localparam int DG_FAST_BIT = 12;
	localparam int DG_DD_LSB = 10;
	localparam int DG_NDF_BIT = 5;
	localparam int DG_AIS_BIT = 3;

	// ------------------------------------------------------------
	// reset values and stream constants
	// ------------------------------------------------------------
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [12:0] COUNT_MAX = 13'h1FFF;
	localparam logic [6:0] STUFF_COL_A = 7'h1E;
	localparam logic [6:0] STUFF_COL_B = 7'h3B;
	localparam logic [7:0] STUFF_FILL = 8'h00;
	localparam logic [7:0] AIS_FILL = 8'hFF;
	localparam logic [3:0] NDF_ENABLED = 4'h9;
	localparam logic [1:0] SLAVE_SS = 2'h0;

	// ------------------------------------------------------------
	// timing in frames and clocks
	// ------------------------------------------------------------
	localparam logic [2:0] JUST_SPACING_FRAMES = 3'h4;
	localparam logic [1:0] AIS_MIN_FRAMES = 2'h3;
	localparam int SNAPSHOT_LIMIT_CYCLES = 12;

	typedef struct packed {
		logic valid;
		logic frame_start;
		logic [3:0] path;
		logic [6:0] col;
		logic is_h1;
		logic is_h2;
		logic is_h3;
		logic is_spe;
		logic [7:0] data;
	} stream_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [15:0] addr;
		logic [15:0] wdata;
	} cpu_req_t;

endpackage

// file: payload_aligner_control_status.sv
// control and status register bank of the receive payload aligner, with the output
// byte path (bypass, stuff regen, forced ais, pointer byte overrides) and justification pacing.
// assumes all inputs come from logic on clk; cpu strobes are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none

module payload_aligner_control_status #(
	parameter int PATHS = 12
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire payload_aligner_pkg::cpu_req_t cpu_bus_port,
	input wire logic master_cfg_wr,
	output logic [15:0] cpu_rdata,
	input wire payload_aligner_pkg::stream_t stream_in,
	input wire payload_aligner_pkg::stream_t store_out,
	input wire logic [11:0] store_overflow,
	input wire logic [11:0] store_underflow,
	input wire logic [11:0] just_req_pos,
	input wire logic [11:0] just_req_neg,
	output payload_aligner_pkg::stream_t stream_out,
	output logic [11:0] just_grant_pos,
	output logic [11:0] just_grant_neg,
	output logic [11:0] pointer_reinit,
	output logic elastic_store_bypass,
	output logic irq
);
	import payload_aligner_pkg::*;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// path number 1..12 to array index; out of range maps to 0 and so reaches the registers of path 1
	function automatic logic [3:0] path_idx(input logic [3:0] p);
		path_idx = (p >= 4'h1 && p <= 4'hC) ? p - 4'h1 : 4'h0;
	endfunction

	// index of the master path of a concatenated payload containing index i
	function automatic logic [3:0] master_of(input logic [3:0] i, input logic [15:0] cfg);
		logic [1:0] grp;
		grp = i[1:0] + 2'(i >= 4'h4) * 2'h0;
		grp = 2'(i % 4'h4);
		if (cfg[PC_STS12C_BIT])
			master_of = 4'h0;
		else if (cfg[grp] || cfg[PC_TUG3_LSB + grp])
			master_of = {2'h0, grp};
		else
			master_of = i;
	endfunction

	function automatic logic [12:0] sat_inc(input logic [12:0] v);
		sat_inc = (v == COUNT_MAX) ? v : v + 13'h1;
	endfunction

	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	logic [11:0] positive_just_flags;
	logic [11:0] negative_just_flags;
	logic [11:0] fifo_overflow_flags;
	logic [11:0] fifo_underflow_flags;
	logic [11:0] justification_irq_enables;
	logic [11:0] fifo_irq_enables;
	logic [11:0] stuff_column_regen;
	logic bypass_ctl;
	logic [15:0] payload_cfg;
	logic [15:0] ind_addr;
	logic [15:0] ind_data;
	logic ind_busy;
	logic [15:0] diag_pointer_config [PATHS];
	logic [12:0] live_pos [PATHS];
	logic [12:0] live_neg [PATHS];
	logic [12:0] positive_just_count [PATHS];
	logic [12:0] negative_just_count [PATHS];
	logic [2:0] frames_since_just [PATHS];
	logic [1:0] ais_frames [PATHS];
	logic [11:0] ais_active;
	logic [11:0] ndf_frame;

	logic wr;
	logic rd;
	logic snapshot;
	logic [3:0] ind_path;
	logic [3:0] ind_master;
	logic [1:0] ind_sel;
	logic [11:0] grant_pos;
	logic [11:0] grant_neg;
	stream_t sel_stream;
	stream_t next_stream_out;
	logic [15:0] next_rdata;

	assign wr = cpu_bus_port.wr;
	assign rd = cpu_bus_port.rd;
	assign snapshot = (wr && cpu_bus_port.addr == OFS_SNAPSHOT) || master_cfg_wr;
	assign ind_path = path_idx(ind_addr[3:0]);
	assign ind_master = master_of(ind_path, payload_cfg);
	assign ind_sel = ind_addr[IA_SEL_LSB +: 2];

	// ------------------------------------------------------------
	// direct control registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			justification_irq_enables <= REG_RESET[11:0];
			fifo_irq_enables <= REG_RESET[11:0];
			stuff_column_regen <= REG_RESET[11:0];
			bypass_ctl <= 1'b0;
			payload_cfg <= REG_RESET;
		end
		else if (wr)
		begin
			case (cpu_bus_port.addr)
				OFS_JUST_IRQ_EN: justification_irq_enables <= cpu_bus_port.wdata[11:0];
				OFS_FIFO_IRQ_EN: fifo_irq_enables <= cpu_bus_port.wdata[11:0];
				OFS_STUFF_REGEN:
				begin
					stuff_column_regen <= cpu_bus_port.wdata[11:0];
					bypass_ctl <= cpu_bus_port.wdata[BYPASS_BIT];
				end
				OFS_PAYLOAD_CFG: payload_cfg <= cpu_bus_port.wdata;
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// event flags: set wins over the read clear
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			positive_just_flags <= REG_RESET[11:0];
			negative_just_flags <= REG_RESET[11:0];
			fifo_overflow_flags <= REG_RESET[11:0];
			fifo_underflow_flags <= REG_RESET[11:0];
		end
		else
		begin
			positive_just_flags <= (rd && cpu_bus_port.addr == OFS_POS_JUST_FLAGS ? 12'h000
				: positive_just_flags) | grant_pos;
			negative_just_flags <= (rd && cpu_bus_port.addr == OFS_NEG_JUST_FLAGS ? 12'h000
				: negative_just_flags) | grant_neg;
			fifo_overflow_flags <= (rd && cpu_bus_port.addr == OFS_OVERFLOW_FLAGS ? 12'h000
				: fifo_overflow_flags) | store_overflow;
			fifo_underflow_flags <= (rd && cpu_bus_port.addr == OFS_UNDERFLOW_FLAGS ? 12'h000
				: fifo_underflow_flags) | store_underflow;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= |((positive_just_flags | negative_just_flags) & justification_irq_enables)
				| |((fifo_overflow_flags | fifo_underflow_flags) & fifo_irq_enables);
	end

	// ------------------------------------------------------------
	// indirect access: one busy cycle, far below the poll software does
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ind_addr <= REG_RESET;
			ind_busy <= 1'b0;
			ind_data <= REG_RESET;
		end
		else
		begin
			// address writes during busy are dropped so an access cannot be retargeted
			if (wr && cpu_bus_port.addr == OFS_IND_ADDR && !ind_busy)
			begin
				ind_addr <= cpu_bus_port.wdata;
				ind_busy <= 1'b1;
			end
			else
				ind_busy <= 1'b0;
			if (ind_busy && ind_addr[IA_RNW_BIT])
			begin
				case (ind_sel)
					IND_POS_COUNT: ind_data <= {3'h0, positive_just_count[ind_master]};
					IND_NEG_COUNT: ind_data <= {3'h0, negative_just_count[ind_master]};
					IND_DIAG: ind_data <= diag_pointer_config[ind_path];
					default: ind_data <= REG_RESET;
				endcase
			end
			else if (wr && cpu_bus_port.addr == OFS_IND_DATA && !ind_busy)
				ind_data <= cpu_bus_port.wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < PATHS; i++)
				diag_pointer_config[i] <= REG_RESET;
		end
		else if (ind_busy && !ind_addr[IA_RNW_BIT] && ind_sel == IND_DIAG)
		begin
			for (int i = 0; i < PATHS; i++)
			begin
				if (4'(i) == ind_path
					|| (ind_path == ind_master && master_of(4'(i), payload_cfg) == ind_master))
					diag_pointer_config[i] <= ind_data;
			end
		end
	end

	// ------------------------------------------------------------
	// justification pacing and performance counters
	// ------------------------------------------------------------
	always_comb
	begin
		for (int i = 0; i < PATHS; i++)
		begin
			grant_pos[i] = just_req_pos[i] && !diag_pointer_config[i][DG_REINIT_BIT]
				&& (diag_pointer_config[i][DG_FAST_BIT]
				|| frames_since_just[i] >= JUST_SPACING_FRAMES);
			grant_neg[i] = just_req_neg[i] && !just_req_pos[i]
				&& !diag_pointer_config[i][DG_REINIT_BIT]
				&& (diag_pointer_config[i][DG_FAST_BIT]
				|| frames_since_just[i] >= JUST_SPACING_FRAMES);
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < PATHS; i++)
				frames_since_just[i] <= JUST_SPACING_FRAMES;
		end
		else
		begin
			for (int i = 0; i < PATHS; i++)
			begin
				if (grant_pos[i] || grant_neg[i])
					frames_since_just[i] <= 3'h0;
				else if (sel_stream.valid && sel_stream.frame_start
					&& frames_since_just[i] < JUST_SPACING_FRAMES)
					frames_since_just[i] <= frames_since_just[i] + 3'h1;
			end
		end
	end

	// snapshot lands in one clock, inside the twelve-clock promise
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < PATHS; i++)
			begin
				live_pos[i] <= 13'h0000;
				live_neg[i] <= 13'h0000;
				positive_just_count[i] <= 13'h0000;
				negative_just_count[i] <= 13'h0000;
			end
		end
		else
		begin
			for (int i = 0; i < PATHS; i++)
			begin
				if (snapshot)
				begin
					positive_just_count[i] <= live_pos[i];
					negative_just_count[i] <= live_neg[i];
					live_pos[i] <= {12'h000, grant_pos[i]};
					live_neg[i] <= {12'h000, grant_neg[i]};
				end
				else
				begin
					if (grant_pos[i])
						live_pos[i] <= sat_inc(live_pos[i]);
					if (grant_neg[i])
						live_neg[i] <= sat_inc(live_neg[i]);
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			just_grant_pos <= 12'h000;
			just_grant_neg <= 12'h000;
			pointer_reinit <= 12'h000;
			elastic_store_bypass <= 1'b0;
		end
		else
		begin
			just_grant_pos <= grant_pos;
			just_grant_neg <= grant_neg;
			for (int i = 0; i < PATHS; i++)
				pointer_reinit[i] <= diag_pointer_config[i][DG_REINIT_BIT];
			elastic_store_bypass <= bypass_ctl;
		end
	end

	// ------------------------------------------------------------
	// forced ais lasts whole frames and is followed by one ndf frame
	// ------------------------------------------------------------
	assign sel_stream = bypass_ctl ? stream_in : store_out;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ais_active <= 12'h000;
			ndf_frame <= 12'h000;
			for (int i = 0; i < PATHS; i++)
				ais_frames[i] <= 2'h0;
		end
		else if (sel_stream.valid && sel_stream.frame_start)
		begin
			for (int i = 0; i < PATHS; i++)
			begin
				ndf_frame[i] <= 1'b0;
				if (diag_pointer_config[i][DG_AIS_BIT])
				begin
					ais_active[i] <= 1'b1;
					if (!ais_active[i])
						ais_frames[i] <= 2'h1;
					else if (ais_frames[i] < AIS_MIN_FRAMES)
						ais_frames[i] <= ais_frames[i] + 2'h1;
				end
				else if (ais_active[i] && ais_frames[i] < AIS_MIN_FRAMES)
					ais_frames[i] <= ais_frames[i] + 2'h1;
				else if (ais_active[i])
				begin
					ais_active[i] <= 1'b0;
					ndf_frame[i] <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// outgoing byte
	// ------------------------------------------------------------
	always_comb
	begin
		logic [3:0] pi;
		logic [3:0] mi;
		logic [15:0] dg;
		pi = path_idx(sel_stream.path);
		mi = master_of(pi, payload_cfg);
		dg = diag_pointer_config[pi];
		next_stream_out = sel_stream;
		if (!bypass_ctl)
		begin
			if (ais_active[pi] && (sel_stream.is_h1 || sel_stream.is_h2
				|| sel_stream.is_h3 || sel_stream.is_spe))
				next_stream_out.data = AIS_FILL;
			else if (sel_stream.is_spe && stuff_column_regen[pi]
				&& (sel_stream.col == STUFF_COL_A || sel_stream.col == STUFF_COL_B))
				next_stream_out.data = STUFF_FILL;
			else if (sel_stream.is_h1 && mi != pi)
				next_stream_out.data = {NDF_ENABLED, SLAVE_SS, dg[DG_DD_LSB +: 2]};
			else if (sel_stream.is_h1)
			begin
				next_stream_out.data[3:2] = dg[DG_SS_LSB +: 2];
				if (dg[DG_NDF_BIT] || ndf_frame[pi])
					next_stream_out.data[7:4] = NDF_ENABLED;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			stream_out <= '0;
		else
			stream_out <= next_stream_out;
	end

	// ------------------------------------------------------------
	// read port: registered data, unmapped reads return zero
	// ------------------------------------------------------------
	always_comb
	begin
		case (cpu_bus_port.addr)
			OFS_IND_ADDR: next_rdata = {ind_busy, ind_addr[14:0]};
			OFS_IND_DATA: next_rdata = ind_data;
			OFS_PAYLOAD_CFG: next_rdata = payload_cfg;
			OFS_POS_JUST_FLAGS: next_rdata = {4'h0, positive_just_flags};
			OFS_NEG_JUST_FLAGS: next_rdata = {4'h0, negative_just_flags};
			OFS_OVERFLOW_FLAGS: next_rdata = {4'h0, fifo_overflow_flags};
			OFS_UNDERFLOW_FLAGS: next_rdata = {4'h0, fifo_underflow_flags};
			OFS_JUST_IRQ_EN: next_rdata = {4'h0, justification_irq_enables};
			OFS_FIFO_IRQ_EN: next_rdata = {4'h0, fifo_irq_enables};
			OFS_STUFF_REGEN: next_rdata = {bypass_ctl, 3'h0, stuff_column_regen};
			default: next_rdata = 16'h0000;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cpu_rdata <= 16'h0000;
		else if (rd)
			cpu_rdata <= next_rdata;
	end

endmodule

`default_nettype wire

// file: aligner_checker.sv
// port-level checks for the payload aligner control and status block.
// assumes it is bound into payload_aligner_control_status, one clock domain.
`timescale 1ns/1ps
`default_nettype none

module aligner_checker
	import payload_aligner_pkg::*;
#(
	parameter int PATHS = 12
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire payload_aligner_pkg::cpu_req_t cpu_bus_port,
	input wire payload_aligner_pkg::stream_t stream_in,
	input wire payload_aligner_pkg::stream_t store_out,
	input wire logic [11:0] store_overflow,
	input wire logic [11:0] store_underflow,
	input wire logic [11:0] just_req_pos,
	input wire logic [11:0] just_req_neg,
	input wire logic [15:0] cpu_rdata,
	input wire payload_aligner_pkg::stream_t stream_out,
	input wire logic [11:0] just_grant_pos,
	input wire logic [11:0] just_grant_neg,
	input wire logic [11:0] pointer_reinit,
	input wire logic elastic_store_bypass,
	input wire logic irq
);
	logic ev_any;
	logic acc;
	assign ev_any = (|{store_overflow, store_underflow, just_req_pos, just_req_neg})
		| cpu_bus_port.wr;
	assign acc = cpu_bus_port.rd | cpu_bus_port.wr;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// a mode write may take one extra cycle to reach the output mux
	sequence quiet_bus;
		!cpu_bus_port.wr && !$past(cpu_bus_port.wr);
	endsequence
	sequence toh_byte;
		!elastic_store_bypass
			&& !(store_out.is_h1 | store_out.is_h2 | store_out.is_h3 | store_out.is_spe);
	endsequence
	sequence byp_set;
		cpu_bus_port.wr && cpu_bus_port.addr == OFS_STUFF_REGEN && cpu_bus_port.wdata[BYPASS_BIT];
	endsequence

	bypass_copy_a: assert property (
		quiet_bus ##0 elastic_store_bypass |=> stream_out == $past(stream_in))
		else $error("bypass output is not last input word");
	toh_pass_a: assert property (quiet_bus ##0 toh_byte |=> stream_out == $past(store_out))
		else $error("plain overhead byte altered");
	bypass_set_a: assert property (byp_set |-> ##[1:2] elastic_store_bypass)
		else $error("bypass output did not follow write");
	grant_cause_a: assert property (
		((just_grant_pos & ~$past(just_req_pos))
		| (just_grant_neg & ~$past(just_req_neg))) == 12'h000)
		else $error("grant without request");
	grant_single_a: assert property ((just_grant_pos & just_grant_neg) == 12'h000)
		else $error("both grants on one path");
	// grant and reinit flops both load from the same cycle's diagnostic word
	reinit_block_a: assert property (
		|pointer_reinit |-> ((just_grant_pos | just_grant_neg) & pointer_reinit) == 12'h000)
		else $error("grant while pointer held in reset");
	rdata_hold_a: assert property (!cpu_bus_port.rd |=> $stable(cpu_rdata))
		else $error("read data moved without read");
	irq_rise_a: assert property (
		$rose(irq) |-> $past(ev_any) || $past(ev_any, 2) || $past(ev_any, 3))
		else $error("interrupt rose without cause");
	irq_fall_a: assert property (
		$fell(irq) |-> $past(acc) || $past(acc, 2) || $past(acc, 3))
		else $error("interrupt fell without access");
endmodule

bind payload_aligner_control_status aligner_checker #(.PATHS(PATHS)) chk (
	.clk(clk), .rst_n(rst_n), .cpu_bus_port(cpu_bus_port), .stream_in(stream_in),
	.store_out(store_out), .store_overflow(store_overflow), .store_underflow(store_underflow),
	.just_req_pos(just_req_pos), .just_req_neg(just_req_neg), .cpu_rdata(cpu_rdata),
	.stream_out(stream_out), .just_grant_pos(just_grant_pos), .just_grant_neg(just_grant_neg),
	.pointer_reinit(pointer_reinit), .elastic_store_bypass(elastic_store_bypass), .irq(irq)
);

`default_nettype wire

// file: frame_source.sv
// upstream byte stream model: twelve interleaved paths, 90 columns a frame.
// assumes clk from the bench; bytes change on the falling edge.
`timescale 1ns/1ps
`default_nettype none

module frame_source
	import payload_aligner_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	output payload_aligner_pkg::stream_t raw,
	output payload_aligner_pkg::stream_t stored
);
	logic [6:0] col;
	logic [3:0] path;

	always_ff @(negedge clk or negedge rst_n)
		if (!rst_n)
		begin
			col <= 7'h00;
			path <= 4'h1;
		end
		else if (path == 4'hC)
		begin
			path <= 4'h1;
			col <= (col == 7'h59) ? 7'h00 : col + 7'h01;
		end
		else
			path <= path + 4'h1;

	// stuff columns carry nonzero bytes so that regeneration is visible
	always_comb
	begin
		raw = '0;
		raw.valid = 1'b1;
		raw.frame_start = (col == 7'h00) && (path == 4'h1);
		raw.path = path;
		raw.col = col;
		raw.is_h1 = col == 7'h01;
		raw.is_h2 = col == 7'h02;
		raw.is_h3 = col == 7'h03;
		raw.is_spe = col > 7'h03;
		raw.data = {col[3:0], path} ^ 8'h5A;
		stored = raw;
		stored.data = ~raw.data;
	end
endmodule

`default_nettype wire

// file: tb.sv
// self-checking bench for the payload aligner control and status block.
// assumes frame_source as upstream model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end

module tb;
	import payload_aligner_pkg::*;
	logic clk, rst_n, master_cfg_wr, byp_o, irq, mon_on, byp, ais_mon, h1_chk;
	cpu_req_t cpu;
	stream_t s_in, st_out, s_out, prev_in, prev_st, e;
	logic [11:0] ovf, udf, rq_p, rq_n, g_p, g_n, reinit, regen;
	logic [15:0] rdata, lf;
	logic [3:0] ais_p;
	int err_total, n_compared, k, i, n_p, n_n;
	logic [15:0] regs [7] = '{OFS_POS_JUST_FLAGS, OFS_NEG_JUST_FLAGS, OFS_OVERFLOW_FLAGS,
		OFS_UNDERFLOW_FLAGS, OFS_JUST_IRQ_EN, OFS_FIFO_IRQ_EN, OFS_STUFF_REGEN};

	payload_aligner_control_status #(.PATHS(NUM_PATHS)) DUT (.clk(clk), .rst_n(rst_n),
		.cpu_bus_port(cpu), .master_cfg_wr(master_cfg_wr), .cpu_rdata(rdata), .stream_in(s_in),
		.store_out(st_out), .store_overflow(ovf), .store_underflow(udf), .just_req_pos(rq_p),
		.just_req_neg(rq_n), .stream_out(s_out), .just_grant_pos(g_p), .just_grant_neg(g_n),
		.pointer_reinit(reinit), .elastic_store_bypass(byp_o), .irq(irq));
	frame_source src (.clk(clk), .rst_n(rst_n), .raw(s_in), .stored(st_out));

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	function automatic logic [15:0] nxt(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	// ------------------------------------------------------------
	// bus and event tasks
	// ------------------------------------------------------------
	task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d);
		@(negedge clk);
		cpu = '{rd: !w, wr: w, addr: a, wdata: d};
		@(negedge clk);
		cpu = '0;
	endtask

	task automatic rd_chk(input logic [15:0] a, input logic [15:0] x, input string nm);
		bus(1'b0, a, 16'h0000);
		`CHK(nm, x, rdata)
	endtask

	task automatic ind(input logic [1:0] sel, input logic [3:0] p, input logic rnw,
		input logic [15:0] d);
		if (!rnw)
			bus(1'b1, OFS_IND_DATA, d);
		bus(1'b1, OFS_IND_ADDR, {1'b0, rnw, 4'h0, sel, 4'h0, p});
		k = 0;
		do
		begin
			bus(1'b0, OFS_IND_ADDR, 16'h0000);
			k++;
		end
		while (rdata[IA_BUSY_BIT] !== 1'b0 && k < 10);
		`CHK("busy cleared", 1'b0, rdata[IA_BUSY_BIT])
		if (rnw)
			bus(1'b0, OFS_IND_DATA, 16'h0000);
	endtask

	task automatic ev(input logic [11:0] o, input logic [11:0] u, input logic [11:0] p,
		input logic [11:0] n);
		@(negedge clk);
		{ovf, udf, rq_p, rq_n} = {o, u, p, n};
		@(negedge clk);
		{ovf, udf, rq_p, rq_n} = 48'h0;
	endtask

	task automatic wf;
		do
			@(negedge clk);
		while (!prev_st.frame_start);
	endtask

	task give_verdict;
		if (err_total == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ------------------------------------------------------------
	// outgoing stream monitor
	// ------------------------------------------------------------
	always @(posedge clk)
	begin
		prev_in <= s_in;
		prev_st <= st_out;
	end

	always @(negedge clk)
		if (mon_on)
		begin
			e = byp ? prev_in : prev_st;
			if (!byp && e.path == ais_p)
			begin
				if (ais_mon && (e.is_h1 | e.is_h2 | e.is_h3 | e.is_spe))
					`CHK("ais byte", AIS_FILL, s_out.data)
			end
			else if (byp || !e.is_h1)
			begin
				if (!byp && regen[e.path - 1] && e.is_spe && (e.col == STUFF_COL_A || e.col == STUFF_COL_B))
					e.data = STUFF_FILL;
				`CHK("stream word", e, s_out)
			end
			else if (h1_chk && e.path == 4'h1)
				`CHK("master h1", 6'h26, s_out.data[7:2])
			else if (h1_chk && e.path == 4'h5)
				`CHK("slave h1", 8'h91, s_out.data)
		end

	initial
	begin
		repeat (16000) @(posedge clk);
		err_total++;
		give_verdict;
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		{rst_n, master_cfg_wr, mon_on, byp, ais_mon, h1_chk} = 6'h00;
		{ovf, udf, rq_p, rq_n, regen, ais_p} = 64'h0;
		cpu = '0;
		lf = 16'h002E;
		err_total = 0;
		n_compared = 0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		foreach (regs[j])
			rd_chk(regs[j], REG_RESET, "reset value");
		bus(1'b1, 16'h020F, 16'hFFFF);
		rd_chk(16'h020F, 16'h0000, "unmapped");
		for (i = 0; i < 4; i++)
		begin
			lf = nxt(lf);
			bus(1'b1, OFS_FIFO_IRQ_EN - 16'(i % 2), {4'h0, lf[11:0]});
			rd_chk(OFS_FIFO_IRQ_EN - 16'(i % 2), {4'h0, lf[11:0]}, "enable rw");
			bus(1'b1, OFS_FIFO_IRQ_EN - 16'(i % 2), 16'h0000);
			ev(lf[11:0], ~lf[11:0], 12'h000, 12'h000);
			rd_chk(OFS_OVERFLOW_FLAGS, {4'h0, lf[11:0]}, "overflow flags");
			rd_chk(OFS_UNDERFLOW_FLAGS, {4'h0, ~lf[11:0]}, "underflow flags");
			rd_chk(OFS_OVERFLOW_FLAGS, 16'h0000, "overflow cleared");
			rd_chk(OFS_UNDERFLOW_FLAGS, 16'h0000, "underflow cleared");
			`CHK("masked irq", 1'b0, irq)
		end
		bus(1'b1, OFS_FIFO_IRQ_EN, 16'h0010);
		ev(12'h008, 12'h000, 12'h000, 12'h000);
		repeat (3) @(negedge clk);
		`CHK("irq masked path", 1'b0, irq)
		ev(12'h000, 12'h010, 12'h000, 12'h000);
		repeat (3) @(negedge clk);
		`CHK("irq enabled path", 1'b1, irq)
		rd_chk(OFS_UNDERFLOW_FLAGS, 16'h0010, "underflow flag");
		rd_chk(OFS_OVERFLOW_FLAGS, 16'h0008, "overflow flag");
		repeat (3) @(negedge clk);
		`CHK("irq after clear", 1'b0, irq)
		bus(1'b1, OFS_PAYLOAD_CFG, 16'h0001);
		ind(IND_DIAG, 4'h1, 1'b0, 16'h5420);
		bus(1'b1, OFS_JUST_IRQ_EN, 16'h0001);
		bus(1'b1, OFS_SNAPSHOT, 16'h0000);
		lf = nxt(lf);
		n_p = 3 + lf[2:0];
		n_n = 1 + lf[5:4];
		for (i = 0; i < n_p; i++)
		begin
			ev(12'h000, 12'h000, 12'h001, 12'h000);
			`CHK("fast pos grant", 12'h001, g_p)
		end
		for (i = 0; i < n_n; i++)
		begin
			ev(12'h000, 12'h000, 12'h000, 12'h001);
			`CHK("fast neg grant", 12'h001, g_n)
		end
		repeat (3) @(negedge clk);
		`CHK("just irq", 1'b1, irq)
		rd_chk(OFS_POS_JUST_FLAGS, 16'h0001, "pos flags");
		rd_chk(OFS_NEG_JUST_FLAGS, 16'h0001, "neg flags");
		bus(1'b1, OFS_SNAPSHOT, 16'hA5A5);
		repeat (SNAPSHOT_LIMIT_CYCLES) @(negedge clk);
		`CHK("irq after flag read", 1'b0, irq)
		ind(IND_POS_COUNT, 4'h1, 1'b1, 16'h0000);
		`CHK("pos count", 16'(n_p), rdata)
		ind(IND_NEG_COUNT, 4'h5, 1'b1, 16'h0000);
		`CHK("slave neg count", 16'(n_n), rdata)
		ev(12'h000, 12'h000, 12'h002, 12'h000);
		`CHK("first grant", 12'h002, g_p)
		ev(12'h000, 12'h000, 12'h002, 12'h000);
		`CHK("spaced grant", 12'h000, g_p)
		bus(1'b1, OFS_STUFF_REGEN, 16'h0004);
		regen = 12'h004;
		{h1_chk, mon_on} = 2'b11;
		repeat (4400) @(negedge clk);
		ev(12'h000, 12'h000, 12'h002, 12'h000);
		`CHK("grant after 4 frames", 12'h002, g_p)
		@(negedge clk) master_cfg_wr = 1'b1;
		@(negedge clk) master_cfg_wr = 1'b0;
		repeat (SNAPSHOT_LIMIT_CYCLES) @(negedge clk);
		ind(IND_POS_COUNT, 4'h2, 1'b1, 16'h0000);
		`CHK("pos count path 2", 16'h0002, rdata)
		ind(IND_POS_COUNT, 4'h1, 1'b1, 16'h0000);
		`CHK("new interval", 16'h0000, rdata)
		ais_p = 4'h2;
		ind(IND_DIAG, 4'h2, 1'b0, 16'h0008);
		wf;
		ais_mon = 1'b1;
		// cleared at once: insertion still has to span three frames
		ind(IND_DIAG, 4'h2, 1'b0, 16'h0000);
		wf;
		wf;
		wf;
		ais_mon = 1'b0;
		do
			@(negedge clk);
		while (!(prev_st.is_h1 && prev_st.path == 4'h2));
		`CHK("new data flag", NDF_ENABLED, s_out.data[7:4])
		h1_chk = 1'b0;
		// path 2 is plain again, so its bytes go back under the stream compare
		ais_p = 4'h0;
		ind(IND_DIAG, 4'h1, 1'b0, 16'h8000);
		`CHK("propagated reinit", 12'h111, reinit)
		ev(12'h000, 12'h000, 12'h001, 12'h000);
		`CHK("grant in reinit", 12'h000, g_p)
		ind(IND_DIAG, 4'h1, 1'b0, 16'h0000);
		`CHK("reinit released", 12'h000, reinit)
		mon_on = 1'b0;
		bus(1'b1, OFS_STUFF_REGEN, 16'h8000);
		byp = 1'b1;
		repeat (2) @(negedge clk);
		`CHK("bypass level", 1'b1, byp_o)
		mon_on = 1'b1;
		repeat (200) @(negedge clk);
		rd_chk(OFS_STUFF_REGEN, 16'h8000, "bypass readback");
		give_verdict;
	end
endmodule

`default_nettype wire
